// ===== core/lfs_supervisor.sv
// fault supervision for a constant-current led driver
module lfs_supervisor #(
  parameter int unsigned DISABLE_CYCLES = lfs_pkg::DISABLE_CYCLES,
  parameter int unsigned OPEN_TIMEOUT_CYCLES = lfs_pkg::OPEN_TIMEOUT_CYCLES,
  parameter int unsigned BLANK_CYCLES = lfs_pkg::BLANK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable_in,
  input wire logic open_circuit_cmp,
  input wire logic ref_short_cmp,
  input wire logic nonref_short_cmp,
  input wire logic string_short_cmp,
  input wire logic fault_flag_primary_in,
  input wire logic pwm_gate_in,
  output logic gate_drive_out,
  output logic fault_flag_primary_out,
  output logic fault_flag_primary_oe,
  output logic fault_flag_secondary_out,
  output logic fault_flag_secondary_oe,
  output logic short_latched,
  output logic sleep_out
);
  localparam int CW = lfs_pkg::CNT_W;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisation
  logic [5:0] raw_in;
  logic [5:0] syn;
  logic en_s;
  logic open_s;
  logic ref_s;
  logic nonref_s;
  logic str_s;
  logic ffp_s;

  assign raw_in = {fault_flag_primary_in, string_short_cmp, nonref_short_cmp,
                   ref_short_cmp, open_circuit_cmp, enable_in};

  lfs_sync #(.WIDTH(6)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(raw_in),
    .sync_out(syn)
  );

  assign en_s = syn[0];
  assign open_s = syn[1];
  assign ref_s = syn[2];
  assign nonref_s = syn[3];
  assign str_s = syn[4];
  assign ffp_s = syn[5];

  ////////////////////////////////////////////////////////////////////////////
  // state
  lfs_pkg::lfs_open_state_t open_st_q;
  lfs_pkg::lfs_open_state_t open_st_d;
  logic [CW-1:0] open_cnt_q;
  logic [CW-1:0] open_cnt_d;
  logic [CW:0] dis_cnt_q;
  logic [CW:0] dis_cnt_d;
  logic [CW-1:0] blank_cnt_q;
  logic [CW-1:0] blank_cnt_d;
  logic blank_done_q;
  logic blank_done_d;
  logic short_q;
  logic short_d;
  logic sleep_q;
  logic sleep_d;
  logic led_short_q;
  logic led_short_d;
  logic gate_q;
  logic gate_d;
  logic ffp_rel_q;
  logic ffp_rel_d;
  logic ffp_rel1_q;
  logic ffp_rel1_d;
  logic ffp_rel2_q;
  logic ffp_rel2_d;
  logic ffs_rel_q;
  logic ffs_rel_d;
  logic open_now;
  logic dis_expired;

  // open acts directly on the synced level, not a registered copy
  assign open_now = open_s && (open_st_q == lfs_pkg::LFS_RUN);
  assign dis_expired = (dis_cnt_q >= (CW+1)'(DISABLE_CYCLES));

  always_comb begin
    open_st_d = open_st_q;
    open_cnt_d = open_cnt_q;
    dis_cnt_d = dis_cnt_q;
    blank_cnt_d = blank_cnt_q;
    blank_done_d = blank_done_q;
    short_d = short_q;
    sleep_d = sleep_q;
    led_short_d = 1'b0;

    if (!blank_done_q) begin
      if (blank_cnt_q >= CW'(BLANK_CYCLES - 1)) begin
        blank_done_d = 1'b1;
      end else begin
        blank_cnt_d = blank_cnt_q + CW'(1);
      end
    end

    // count enable-low time in oscillator periods
    if (en_s) begin
      dis_cnt_d = '0;
      sleep_d = 1'b0;
    end else if (!dis_expired) begin
      dis_cnt_d = dis_cnt_q + (CW+1)'(1);
    end else begin
      sleep_d = 1'b1;
    end

    case (open_st_q)
      lfs_pkg::LFS_RUN: begin
        // re-evaluated each time run is re-entered
        if (open_s) begin
          open_st_d = lfs_pkg::LFS_OPEN_HOLD;
          open_cnt_d = '0;
        end
      end
      lfs_pkg::LFS_OPEN_HOLD: begin
        if (open_cnt_q >= CW'(OPEN_TIMEOUT_CYCLES - 1)) begin
          // back to run; a persisting open re-trips
          open_st_d = lfs_pkg::LFS_RUN;
        end else begin
          open_cnt_d = open_cnt_q + CW'(1);
        end
      end
      default: begin
        open_st_d = lfs_pkg::LFS_RUN;
      end
    endcase

    // latch short; clear only after long enable-low
    if (dis_expired) begin
      short_d = 1'b0;
    end
    // string below threshold is a string or output short
    if (blank_done_q && str_s && !dis_expired) begin
      short_d = 1'b1;
    end

    // either comparison flags a shorted led
    if (blank_done_q) begin
      led_short_d = ref_s || nonref_s;
    end

    gate_d = en_s && pwm_gate_in;
    if (open_st_d == lfs_pkg::LFS_OPEN_HOLD) begin
      gate_d = 1'b0;
    end
    // short stops drive; flag pulled low overrides
    // pin trusted only once our own release has crossed the synchroniser,
    // else the stale pulled-low level would open the gate for two cycles
    if (short_d && !(short_q && ffp_rel2_q && !ffp_s)) begin
      gate_d = 1'b0;
    end
    // led short leaves gate drive alone

    ffp_rel_d = short_d;
    ffp_rel1_d = ffp_rel_q;
    ffp_rel2_d = ffp_rel1_q;
    // secondary released on open or led short
    ffs_rel_d = (open_st_d == lfs_pkg::LFS_OPEN_HOLD) || led_short_d;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      open_st_q <= lfs_pkg::LFS_RUN;
      open_cnt_q <= '0;
      dis_cnt_q <= '0;
      blank_cnt_q <= '0;
      blank_done_q <= 1'b0;
      short_q <= 1'b0;
      sleep_q <= 1'b0;
      led_short_q <= 1'b0;
      gate_q <= 1'b0;
      ffp_rel_q <= 1'b0;
      ffp_rel1_q <= 1'b0;
      ffp_rel2_q <= 1'b0;
      ffs_rel_q <= 1'b0;
    end else begin
      open_st_q <= open_st_d;
      open_cnt_q <= open_cnt_d;
      dis_cnt_q <= dis_cnt_d;
      blank_cnt_q <= blank_cnt_d;
      blank_done_q <= blank_done_d;
      short_q <= short_d;
      sleep_q <= sleep_d;
      led_short_q <= led_short_d;
      gate_q <= gate_d;
      ffp_rel_q <= ffp_rel_d;
      ffp_rel1_q <= ffp_rel1_d;
      ffp_rel2_q <= ffp_rel2_d;
      ffs_rel_q <= ffs_rel_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; open gating is combinational so no cycle is lost
  // immediate gate cut on open
  assign gate_drive_out = gate_q && !open_now;
  assign fault_flag_primary_out = 1'b0;
  assign fault_flag_primary_oe = !ffp_rel_q;
  assign fault_flag_secondary_out = 1'b0;
  assign fault_flag_secondary_oe = !(ffs_rel_q || open_now);
  assign short_latched = short_q;
  assign sleep_out = sleep_q;
endmodule : lfs_supervisor

// ===== core/lfs_pkg.sv
// constants and state type for the led string fault supervisor
package lfs_pkg;
  // disable time as a ratio of oscillator periods
  localparam int unsigned DISABLE_RATIO = 32768;
  localparam int unsigned DISABLE_CYCLES = DISABLE_RATIO;
  // default open fault time-out, in clock cycles
  localparam int unsigned OPEN_TIMEOUT_CYCLES = 8192;
  // default start-up blanking, in clock cycles
  localparam int unsigned BLANK_CYCLES = 1024;
  localparam int unsigned CNT_W = 16;
  localparam logic SYNC_RESET_VAL = 1'b0;

  typedef enum logic [1:0] {
    LFS_RUN = 2'b00,
    LFS_OPEN_HOLD = 2'b01
  } lfs_open_state_t;
endpackage : lfs_pkg

// ===== core/lfs_sync.sv
// two-stage synchroniser for a bundle of asynchronous levels
module lfs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q <= {WIDTH{lfs_pkg::SYNC_RESET_VAL}};
      sync_q <= {WIDTH{lfs_pkg::SYNC_RESET_VAL}};
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : lfs_sync

// ===== test/lfs_props.sv
// assertions on supervisor ports
module lfs_props #(
  parameter int unsigned DISABLE_CYCLES = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable_in,
  input wire logic open_circuit_cmp,
  input wire logic string_short_cmp,
  input wire logic fault_flag_primary_in,
  input wire logic gate_drive_out,
  input wire logic fault_flag_primary_oe,
  input wire logic fault_flag_secondary_oe,
  input wire logic short_latched,
  input wire logic sleep_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] off_q;
  logic [7:0] off_d;
  // saturates so a long sleep cannot wrap
  always_comb off_d = enable_in ? 8'h00 : off_q + {7'h00, off_q != 8'hFF};
  always_ff @(posedge core_clk) off_q <= rst ? 8'h00 : off_d;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  //////////
  property p_og; open_circuit_cmp [*2] |=> !gate_drive_out; endproperty
  a_og: assert property (p_og) else $error("gate on in open");
  property p_of; open_circuit_cmp [*2] |=> !fault_flag_secondary_oe; endproperty
  a_of: assert property (p_of) else $error("flag2 held");
  property p_sl; $rose(short_latched) |-> $past(string_short_cmp, 3); endproperty
  a_sl: assert property (p_sl) else $error("latch no cause");
  // enable seen high for four samples has crossed the sync, so no clear may be pending
  property p_kp; enable_in [*4] ##0 short_latched |=> short_latched; endproperty
  a_kp: assert property (p_kp) else $error("latch lost");
  property p_po; fault_flag_primary_oe != short_latched; endproperty
  a_po: assert property (p_po) else $error("flag1 wrong");
  property p_sg; (short_latched && fault_flag_primary_in) [*4] |-> !gate_drive_out; endproperty
  a_sg: assert property (p_sg) else $error("gate on in short");
  property p_sh; $rose(short_latched) |-> (!gate_drive_out) [*3]; endproperty
  a_sh: assert property (p_sh) else $error("gate on at latch");
  property p_en; (!enable_in) [*4] |-> !gate_drive_out; endproperty
  a_en: assert property (p_en) else $error("gate on disabled");
  property p_sp;
    $rose(sleep_out) |-> off_q >= DISABLE_CYCLES && off_q <= DISABLE_CYCLES + 6;
  endproperty
  a_sp: assert property (p_sp) else $error("sleep time");
  property p_cl; sleep_out |=> !short_latched; endproperty
  a_cl: assert property (p_cl) else $error("no clear");
endmodule : lfs_props

// ===== test/lfs_cmp_model.sv
// far-side comparators and primary flag pin
module lfs_cmp_model (
  input wire logic [3:0] cond,
  input wire logic flag_oe,
  input wire logic ext_low,
  output logic open_cmp,
  output logic ref_cmp,
  output logic nonref_cmp,
  output logic str_cmp,
  output logic flag_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  assign {open_cmp, ref_cmp, nonref_cmp, str_cmp} = cond;
  // pull-up, either party may sink it
  assign flag_pin = !(flag_oe || ext_low);
endmodule : lfs_cmp_model

// ===== test/lfs_supervisor_test.sv
// self-checking bench for the supervisor
module lfs_supervisor_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned DIS = 16;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b1;
  logic pwm = 1'b1;
  logic xl = 1'b0;
  logic [3:0] c = 4'h0;
  logic oc, rc, nc, sc, pin, gate, po, se, lat, slp, fpo, fso;
  int mismatches = 0;
  int n_compared = 0;
  // {en, pwm, ref, nonref, gate, primary oe, secondary oe}
  logic [6:0] rows [6] = '{7'h67, 7'h76, 7'h6E, 7'h23, 7'h43, 7'h67};
  initial forever #25 core_clk = ~core_clk;
  lfs_cmp_model cmp (.cond(c), .flag_oe(po), .ext_low(xl), .open_cmp(oc), .ref_cmp(rc),
    .nonref_cmp(nc), .str_cmp(sc), .flag_pin(pin));
  lfs_supervisor #(.DISABLE_CYCLES(DIS), .OPEN_TIMEOUT_CYCLES(8), .BLANK_CYCLES(4)) dut (
    .core_clk, .rst, .enable_in(en), .open_circuit_cmp(oc), .ref_short_cmp(rc),
    .nonref_short_cmp(nc), .string_short_cmp(sc), .fault_flag_primary_in(pin),
    .pwm_gate_in(pwm), .gate_drive_out(gate), .fault_flag_primary_out(fpo),
    .fault_flag_primary_oe(po), .fault_flag_secondary_out(fso), .fault_flag_secondary_oe(se),
    .short_latched(lat), .sleep_out(slp));
  //////////
  task automatic w(input int n);
    repeat (n) @(negedge core_clk);
  endtask : w
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  //////////
  initial begin
    repeat (4) @(posedge core_clk);
    w(1);
    chk({gate, po, se}, 3'h3);
    chk({1'b0, fpo, fso}, 3'h0);
    @(posedge core_clk);
    rst <= 1'b0;
    c <= 4'h9;
    @(posedge core_clk);
    c[0] <= 1'b0;
    w(2);
    chk({2'h0, se}, 3'h0);
    @(posedge core_clk);
    c[3] <= 1'b0;
    w(20);
    chk({gate, lat, se}, 3'h5);
    foreach (rows[i]) begin
      @(posedge core_clk);
      {en, pwm, c[2], c[1]} <= rows[i][6:3];
      w(5);
      chk({gate, po, se}, rows[i][2:0]);
    end
    @(posedge core_clk);
    c[3] <= 1'b1;
    w(2);
    chk({1'b0, gate, se}, 3'h3);
    w(1);
    chk({1'b0, gate, se}, 3'h0);
    @(posedge core_clk);
    c[3] <= 1'b0;
    w(5);
    chk({1'b0, gate, se}, 3'h0);
    w(10);
    chk({1'b0, gate, se}, 3'h3);
    @(posedge core_clk);
    c[3] <= 1'b1;
    w(2);
    repeat (30) begin
      w(1);
      chk({1'b0, gate, se}, 3'h0);
    end
    @(posedge core_clk);
    c[3] <= 1'b0;
    w(16);
    chk({1'b0, gate, se}, 3'h3);
    @(posedge core_clk);
    c[0] <= 1'b1;
    w(4);
    chk({gate, po, lat}, 3'h1);
    // our own release must not read back as an external override
    w(2);
    chk({gate, po, lat}, 3'h1);
    // override while the string cause is already gone
    @(posedge core_clk);
    c[0] <= 1'b0;
    xl <= 1'b1;
    w(5);
    chk({gate, po, lat}, 3'h5);
    @(posedge core_clk);
    xl <= 1'b0;
    w(5);
    chk({gate, po, lat}, 3'h1);
    @(posedge core_clk);
    en <= 1'b0;
    w(8);
    @(posedge core_clk);
    en <= 1'b1;
    w(5);
    chk({gate, po, lat}, 3'h1);
    @(posedge core_clk);
    en <= 1'b0;
    w(DIS + 8);
    chk({slp, gate, lat}, 3'h4);
    @(posedge core_clk);
    en <= 1'b1;
    w(6);
    chk({gate, po, lat}, 3'h6);
    // a power-on reset also clears a latched short
    @(posedge core_clk);
    c[0] <= 1'b1;
    w(4);
    chk({gate, po, lat}, 3'h1);
    @(posedge core_clk);
    rst <= 1'b1;
    c[0] <= 1'b0;
    w(2);
    chk({gate, po, lat}, 3'h2);
    @(posedge core_clk);
    rst <= 1'b0;
    w(8);
    chk({gate, po, lat}, 3'h6);
    summarize();
  end
  initial begin
    repeat (1000) @(posedge core_clk);
    mismatches++;
    summarize();
  end
endmodule : lfs_supervisor_test
bind lfs_supervisor lfs_props #(.DISABLE_CYCLES(DISABLE_CYCLES)) u_props (.core_clk, .rst,
  .enable_in, .open_circuit_cmp, .string_short_cmp, .fault_flag_primary_in, .gate_drive_out,
  .fault_flag_primary_oe, .fault_flag_secondary_oe, .short_latched, .sleep_out);
